/* File: src/tas_pkg.sv */
// constants for the thermal alert and status block
`default_nettype none
package tas_pkg;
   // register offsets
   localparam logic [7:0] ADDR_STATUS_PRI = 8'h41;
   localparam logic [7:0] ADDR_STATUS_SEC = 8'h42;
   localparam logic [7:0] ADDR_MASK_PRI = 8'h74;
   localparam logic [7:0] ADDR_MASK_SEC = 8'h75;
   localparam logic [7:0] ADDR_ALERT_BOOST_CFG = 8'h78;
   localparam logic [7:0] ADDR_HOT_ACC = 8'h79;
   localparam logic [7:0] ADDR_HOT_LIMIT = 8'h7A;
   localparam logic [7:0] ADDR_PIN_FUNC_CFG = 8'h7D;
   // values after reset, on unmapped reads and at full scale
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_HOT_LIMIT = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [7:0] ACC_FULL = 8'hFF;
   // primary status / mask bit positions
   localparam int BIT_SECOND_BANK_PENDING = 7;
   localparam int BIT_REMOTE_TWO_TEMP_FLAG = 6;
   localparam int BIT_LOCAL_TEMP_FLAG = 5;
   localparam int BIT_REMOTE_ONE_TEMP_FLAG = 4;
   localparam int BIT_MAIN_SUPPLY_FLAG = 2;
   localparam int BIT_CORE_SUPPLY_FLAG = 1;
   localparam int MASK_CORE_SUPPLY = 0;
   // secondary status / mask bit positions
   localparam int BIT_DIODE_TWO_FAULT = 7;
   localparam int BIT_DIODE_ONE_FAULT = 6;
   localparam int BIT_FOURTH_FAN_OR_HOT_LIMIT = 5;
   localparam int BIT_THIRD_FAN_SLOW = 4;
   localparam int BIT_SECOND_FAN_SLOW = 3;
   localparam int BIT_FIRST_FAN_SLOW = 2;
   localparam int BIT_OVERTEMP_TRIP = 1;
   // alert_boost_config bits
   localparam int CFG_ALERT_ENABLE = 0;
   localparam int CFG_HOT_ENABLE = 1;
   localparam int CFG_BOOST = 2;
   // analog channel indices
   localparam int CH_CORE = 0;
   localparam int CH_MAIN = 1;
   localparam int CH_REMOTE_ONE = 2;
   localparam int CH_LOCAL = 3;
   localparam int CH_REMOTE_TWO = 4;
   localparam int NUM_CH = 5;
   // shared pin function select
   typedef enum logic [1:0] {
      PIN_FOURTH_SPEED = 2'h0,
      PIN_HOT_SIGNAL = 2'h1,
      PIN_ALERT = 2'h2,
      PIN_GPIO = 2'h3
   } tas_pin_func_e;
   // hot-time resolution
   localparam int HOT_LSB_TIME_US = 22760;
   localparam int CLK_PERIOD_NS = 8;
   localparam int HOT_TICK_CYCLES = (HOT_LSB_TIME_US * 1000) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

/* File: src/tas_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tas_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage <= RESET_VAL;
         syncOut <= RESET_VAL;
      end else begin
         stage <= asyncIn;
         syncOut <= stage;
      end
   end
endmodule
`default_nettype wire

/* File: src/tas_status_logic.sv */
// status, mask, alert pin and hot-time logic
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - primary bit 7 is set while any secondary flag is set
// - primary bits 6,5,4,2,1 flag remote-2, local, remote-1, main and core supply limits
// - secondary bits 7 and 6 flag diode 2 and diode 1 open or short
// - secondary bits 4..2 flag slow fans 3..1; bit 1 flags overtemperature
// - secondary bit 5 flags slow fan 4, or hot-time limit in hot mode
// - flags are sticky; a read clears only flags whose cause is gone
// - alert holds low while an unmasked flag stands or remains unread
// - mask bits only gate the alert, flags still set
// - primary mask bits 7,6,5,4,2,0 gate second bank, temps, main and core
// - secondary mask bits 7..1 gate diodes, fan 4 or hot, fans 3..1, overtemp
// - alert off after reset; config bit 0 drives dedicated alert pin
// - pin function bits 1:0 pick speed input, hot input, alert or gpio
// - hot input works only when config bit 1 is also set
// - boost bit forces full fan duty while hot input is low, three clocks delayed
// - boost has no effect unless the fan is already running
// - hot-time counts during assertion, pauses otherwise, cumulative
// - accumulator clears on read and saturates at full scale
// - bit 0 set on first assertion; later one count per 22.76 ms
// - read during assertion clears then restarts at one
// - read during assertion with zero limit sets secondary bit 5 again
// - accumulator read clears secondary bit 5 set by the hot limit
// - accumulator above hot limit sets secondary bit 5 and alerts
// - high limit violated when greater, low when less or equal
module tas_status_logic
   import tas_pkg::*;
#(
   parameter int HOT_TICK = HOT_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic [NUM_CH-1:0][7:0] measValue,
   input wire logic [NUM_CH-1:0][7:0] limitHigh,
   input wire logic [NUM_CH-1:0][7:0] limitLow,
   input wire logic [NUM_CH-1:0] measDone,
   input wire logic diodeOneFault,
   input wire logic diodeTwoFault,
   input wire logic firstFanSlow,
   input wire logic secondFanSlow,
   input wire logic thirdFanSlow,
   input wire logic fourthFanSlow,
   input wire logic overtempTrip,
   input wire logic fanRunning,
   input wire logic gpioDriveLow,
   output logic alertPinOut,
   output logic alertPinOe,
   input wire logic sharedPinIn,
   output logic sharedPinOut,
   output logic sharedPinOe,
   output logic fourthSpeedInput,
   output logic gpioLevel,
   output logic boostAllFans
);
   localparam int SUB_W = $clog2(HOT_TICK);

   if (HOT_TICK < 2) begin : g_bad_tick
      $error("HOT_TICK must be at least 2");
   end

   // high limit strictly above, low limit at or below
   function automatic logic outOfLimit(input logic [7:0] val, input logic [7:0] lo, input logic [7:0] hi);
      outOfLimit = (val > hi) || (val <= lo);
   endfunction

   logic [7:0] statusPri;
   logic [7:0] statusSec;
   logic [7:0] maskPri;
   logic [7:0] maskSec;
   logic [7:0] alertBoostCfg;
   logic [7:0] hotLimit;
   logic [7:0] pinFuncCfg;
   logic [NUM_CH-1:0] chanOut;
   logic [7:0] condPri;
   logic [7:0] condSec;
   logic [7:0] next_statusPri;
   logic [7:0] next_statusSec;
   logic [7:0] accTicks;
   logic accSeen;
   logic [7:0] accValue;
   logic [SUB_W-1:0] subCount;
   logic pinSync;
   logic hotMode;
   logic hotActive;
   logic alertActive;
   logic rdPri;
   logic rdSec;
   logic rdAcc;
   tas_pin_func_e pinFunc;

   // shared pin passes two flops before use
   tas_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(sharedPinIn),
      .syncOut(pinSync)
   );

   // read strobes and pin mode decode
   assign rdPri = regRead && (regAddr == ADDR_STATUS_PRI);
   assign rdSec = regRead && (regAddr == ADDR_STATUS_SEC);
   assign rdAcc = regRead && (regAddr == ADDR_HOT_ACC);
   assign pinFunc = tas_pin_func_e'(pinFuncCfg[1:0]);
   assign hotMode = (pinFunc == PIN_HOT_SIGNAL) && alertBoostCfg[CFG_HOT_ENABLE];
   assign hotActive = hotMode && !pinSync;

   // window comparison result held per channel until next measurement
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chanOut <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (measDone[i]) begin
               chanOut[i] <= outOfLimit(measValue[i], limitLow[i], limitHigh[i]);
            end
         end
      end
   end

   // accumulator value: one on first assertion, then whole ticks
   assign accValue = (accSeen && (accTicks == 8'h00)) ? 8'h01 : accTicks;

   // live error conditions
   always_comb begin
      condPri = 8'h00;
      condPri[BIT_REMOTE_TWO_TEMP_FLAG] = chanOut[CH_REMOTE_TWO];
      condPri[BIT_LOCAL_TEMP_FLAG] = chanOut[CH_LOCAL];
      condPri[BIT_REMOTE_ONE_TEMP_FLAG] = chanOut[CH_REMOTE_ONE];
      condPri[BIT_MAIN_SUPPLY_FLAG] = chanOut[CH_MAIN];
      condPri[BIT_CORE_SUPPLY_FLAG] = chanOut[CH_CORE];
      condSec = 8'h00;
      condSec[BIT_DIODE_TWO_FAULT] = diodeTwoFault;
      condSec[BIT_DIODE_ONE_FAULT] = diodeOneFault;
      condSec[BIT_THIRD_FAN_SLOW] = thirdFanSlow;
      condSec[BIT_SECOND_FAN_SLOW] = secondFanSlow;
      condSec[BIT_FIRST_FAN_SLOW] = firstFanSlow;
      condSec[BIT_OVERTEMP_TRIP] = overtempTrip;
      if (hotMode) begin
         condSec[BIT_FOURTH_FAN_OR_HOT_LIMIT] = accValue > hotLimit;
      end else begin
         condSec[BIT_FOURTH_FAN_OR_HOT_LIMIT] = (pinFunc == PIN_FOURTH_SPEED) && fourthFanSlow;
      end
   end

   // sticky flags: a read keeps only flags whose cause still stands
   always_comb begin
      next_statusPri = rdPri ? condPri : (statusPri | condPri);
      next_statusSec = rdSec ? condSec : (statusSec | condSec);
      if (rdAcc && hotMode) begin
         next_statusSec[BIT_FOURTH_FAN_OR_HOT_LIMIT] = hotActive && (hotLimit == 8'h00);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         statusPri <= 8'h00;
         statusSec <= 8'h00;
      end else begin
         statusPri <= next_statusPri;
         statusSec <= next_statusSec;
      end
   end

   // host-written registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         maskPri <= RST_MASK;
         maskSec <= RST_MASK;
         alertBoostCfg <= RST_CFG;
         hotLimit <= RST_HOT_LIMIT;
         pinFuncCfg <= RST_CFG;
      end else if (regWrite) begin
         unique case (regAddr)
            ADDR_MASK_PRI: maskPri <= regWdata;
            ADDR_MASK_SEC: maskSec <= regWdata;
            ADDR_ALERT_BOOST_CFG: alertBoostCfg <= regWdata;
            ADDR_HOT_LIMIT: hotLimit <= regWdata;
            ADDR_PIN_FUNC_CFG: pinFuncCfg <= regWdata;
            default: ;
         endcase
      end
   end

   // hot-time accumulator, cumulative and saturating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accTicks <= 8'h00;
         accSeen <= 1'b0;
         subCount <= '0;
      end else if (rdAcc) begin
         accTicks <= 8'h00;
         subCount <= '0;
         accSeen <= hotActive;
      end else if (hotActive) begin
         accSeen <= 1'b1;
         if (accTicks != ACC_FULL) begin
            if (subCount == SUB_W'(HOT_TICK - 1)) begin
               subCount <= '0;
               accTicks <= accTicks + 8'h01;
            end else begin
               subCount <= subCount + 1'b1;
            end
         end
      end
   end

   // alert source gating; mask never touches the flags
   always_comb begin
      alertActive = 1'b0;
      for (int b = BIT_REMOTE_ONE_TEMP_FLAG; b <= BIT_REMOTE_TWO_TEMP_FLAG; b++) begin
         alertActive |= statusPri[b] && !maskPri[b];
      end
      alertActive |= statusPri[BIT_MAIN_SUPPLY_FLAG] && !maskPri[BIT_MAIN_SUPPLY_FLAG];
      alertActive |= statusPri[BIT_CORE_SUPPLY_FLAG] && !maskPri[MASK_CORE_SUPPLY];
      alertActive |= |(statusSec & ~maskSec & 8'hFE) && !maskPri[BIT_SECOND_BANK_PENDING];
   end

   // pin drivers, all open drain pulling low
   assign alertPinOut = 1'b0;
   assign sharedPinOut = 1'b0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alertPinOe <= 1'b0;
         sharedPinOe <= 1'b0;
         fourthSpeedInput <= 1'b1;
         gpioLevel <= 1'b1;
         boostAllFans <= 1'b0;
      end else begin
         alertPinOe <= alertBoostCfg[CFG_ALERT_ENABLE] && alertActive;
         sharedPinOe <= ((pinFunc == PIN_ALERT) && alertActive) || ((pinFunc == PIN_GPIO) && gpioDriveLow);
         fourthSpeedInput <= (pinFunc == PIN_FOURTH_SPEED) ? pinSync : 1'b1;
         gpioLevel <= pinSync;
         boostAllFans <= alertBoostCfg[CFG_BOOST] && hotActive && fanRunning;
      end
   end

   // read data; bit 7 of primary mirrors the second bank
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         unique case (regAddr)
            ADDR_STATUS_PRI: regRdata <= {|statusSec, statusPri[6:0]};
            ADDR_STATUS_SEC: regRdata <= statusSec;
            ADDR_MASK_PRI: regRdata <= maskPri;
            ADDR_MASK_SEC: regRdata <= maskSec;
            ADDR_ALERT_BOOST_CFG: regRdata <= alertBoostCfg;
            ADDR_HOT_ACC: regRdata <= accValue;
            ADDR_HOT_LIMIT: regRdata <= hotLimit;
            ADDR_PIN_FUNC_CFG: regRdata <= pinFuncCfg;
            default: regRdata <= READ_UNMAPPED;
         endcase
      end
   end

   // checks
   bank_pending_a: assert property (@(posedge clk) disable iff (!rst_n)
      rdPri && |statusSec |=> regRdata[BIT_SECOND_BANK_PENDING])
      else $error("pending bit missing on primary read");
   remote_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      chanOut[CH_REMOTE_ONE] |=> statusPri[BIT_REMOTE_ONE_TEMP_FLAG])
      else $error("remote one flag not set");
   diode_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      diodeOneFault |=> statusSec[BIT_DIODE_ONE_FAULT])
      else $error("diode one flag not set");
   fan_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      firstFanSlow |=> statusSec[BIT_FIRST_FAN_SLOW])
      else $error("fan one flag not set");
   sticky_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      statusPri[BIT_LOCAL_TEMP_FLAG] && !rdPri |=> statusPri[BIT_LOCAL_TEMP_FLAG])
      else $error("flag cleared without read");
   masked_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      maskPri[MASK_CORE_SUPPLY] && chanOut[CH_CORE] |=> statusPri[BIT_CORE_SUPPLY_FLAG])
      else $error("masked source did not set flag");
   alert_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
      alertBoostCfg[CFG_ALERT_ENABLE] && statusSec[BIT_OVERTEMP_TRIP] && !maskSec[BIT_OVERTEMP_TRIP]
      && !maskPri[BIT_SECOND_BANK_PENDING] |=> alertPinOe)
      else $error("unmasked flag did not drive alert");
   alert_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      !alertBoostCfg[CFG_ALERT_ENABLE] |=> !alertPinOe)
      else $error("alert pin driven while disabled");
   boost_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      boostAllFans |-> $past(fanRunning) && $past(hotActive))
      else $error("boost without running fan or hot input");
   acc_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
      accTicks == ACC_FULL && !rdAcc |=> accTicks == ACC_FULL)
      else $error("accumulator left full scale");
   acc_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
      rdAcc && hotActive |=> accTicks == 8'h00 && accValue == 8'h01)
      else $error("accumulator did not restart at one");
   hot_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
      hotMode && accValue > hotLimit && !rdAcc |=> statusSec[BIT_FOURTH_FAN_OR_HOT_LIMIT])
      else $error("hot limit exceed not flagged");
endmodule
`default_nettype wire

/* File: sim/tas_hot_source.sv */
// far-side model that pulls the hot line low for whole link periods
`timescale 1ns/1ps
`default_nettype none
module tas_hot_source (
   input wire logic linkClk,
   input wire logic startReq,
   input wire logic [7:0] nPeriods,
   output logic pinLow,
   output logic busy
);
   int left = 0;
   initial begin
      pinLow = 1'b0;
      busy = 1'b0;
   end
   // pulse timed by its own clock, unrelated to the block clock
   always @(posedge linkClk) begin
      if (left > 0) begin
         left = left - 1;
         if (left == 0) begin
            pinLow <= 1'b0; // released, the pull-up takes the line high
            busy <= 1'b0;
         end
      end else if (startReq && !busy) begin
         left = nPeriods;
         pinLow <= 1'b1;
         busy <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the status, mask and hot-time logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin errCount++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
   import tas_pkg::*;
   localparam int HT = 8;
   logic clk, linkClk, rst_n, regWrite, regRead, fanRunning, gpioDriveLow, hotReq;
   logic [7:0] regAddr, regWdata, regRdata, rdv, hotLen;
   logic [NUM_CH-1:0][7:0] measValue, limitHigh, limitLow;
   logic [NUM_CH-1:0] measDone;
   logic [6:0] faults;
   logic alertPinOut, alertPinOe, sharedPinOut, sharedPinOe, fourthSpeedInput, gpioLevel, boostAllFans;
   logic hotLow, hotBusy;
   wire pinWire = ~(hotLow | sharedPinOe);
   int errCount = 0, nChecks = 0, lowCnt = 0;
   int chBit [NUM_CH] = '{BIT_CORE_SUPPLY_FLAG, BIT_MAIN_SUPPLY_FLAG, BIT_REMOTE_ONE_TEMP_FLAG,
                          BIT_LOCAL_TEMP_FLAG, BIT_REMOTE_TWO_TEMP_FLAG};
   logic [7:0] regs [9] = '{ADDR_STATUS_PRI, ADDR_STATUS_SEC, ADDR_MASK_PRI, ADDR_MASK_SEC, ADDR_ALERT_BOOST_CFG,
                            ADDR_HOT_ACC, ADDR_HOT_LIMIT, ADDR_PIN_FUNC_CFG, 8'h50};
   tas_status_logic #(.HOT_TICK(HT)) i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .measValue(measValue), .limitHigh(limitHigh),
      .limitLow(limitLow), .measDone(measDone), .diodeOneFault(faults[5]), .diodeTwoFault(faults[6]),
      .firstFanSlow(faults[1]), .secondFanSlow(faults[2]), .thirdFanSlow(faults[3]), .fourthFanSlow(faults[4]),
      .overtempTrip(faults[0]), .fanRunning(fanRunning), .gpioDriveLow(gpioDriveLow), .alertPinOut(alertPinOut),
      .alertPinOe(alertPinOe), .sharedPinIn(pinWire), .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe),
      .fourthSpeedInput(fourthSpeedInput), .gpioLevel(gpioLevel), .boostAllFans(boostAllFans));
   tas_hot_source i_hot (.linkClk(linkClk), .startReq(hotReq), .nPeriods(hotLen), .pinLow(hotLow), .busy(hotBusy));
   // clocks: block clock 8 ns, link clock 80 ns with its own phase
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      linkClk = 1'b0;
      #3;
      forever #40 linkClk = ~linkClk;
   end
   // counts block-clock edges that see the hot line low
   always @(posedge clk) begin
      if (!pinWire) lowCnt++;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a; regWdata = d; regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      regAddr = a; regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      rdv = regRdata;
      `CHK(rdv, e)
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      regAddr = a; regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
   endtask
   task automatic measure(input int c, input logic [7:0] v);
      @(negedge clk);
      measValue[c] = v; measDone[c] = 1'b1;
      @(negedge clk);
      measDone[c] = 1'b0;
   endtask
   task automatic pulse_ovt();
      @(negedge clk);
      faults[0] = 1'b1;
      @(negedge clk);
      faults[0] = 1'b0;
      cyc(3);
   endtask
   task automatic hot_start(input logic [7:0] n);
      int k;
      @(negedge clk);
      hotLen = n; hotReq = 1'b1;
      for (k = 0; k < 50 && !hotBusy; k++) @(negedge clk);
      hotReq = 1'b0;
      for (k = 0; k < 50 && pinWire; k++) @(negedge clk);
      cyc(5);
   endtask
   task automatic hot_wait();
      int k;
      for (k = 0; k < 3000 && hotBusy; k++) @(negedge clk);
      cyc(5);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #200us;
      errCount++;
      final_report();
   end
   initial begin
      rst_n = 1'b0; regAddr = 8'h00; regWdata = 8'h00; regWrite = 1'b0; regRead = 1'b0;
      measValue = {NUM_CH{8'h40}};
      limitHigh = {NUM_CH{8'h80}};
      limitLow = {NUM_CH{8'h10}};
      measDone = '0; faults = '0; fanRunning = 1'b1; gpioDriveLow = 1'b0; hotReq = 1'b0; hotLen = 8'h01;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      `CHK(alertPinOe, 1'b0)
      `CHK(alertPinOut, 1'b0)
      `CHK(sharedPinOut, 1'b0)
      // reset values, unmapped read, read/write and read-only places
      for (int i = 0; i < 9; i++) chk_rd(regs[i], 8'h00);
      for (int i = 2; i < 8; i++) begin
         if (i == 5) continue;
         wr(regs[i], 8'hA4);
         chk_rd(regs[i], 8'hA4);
         wr(regs[i], 8'h00);
      end
      wr(ADDR_STATUS_SEC, 8'hFF);
      chk_rd(ADDR_STATUS_SEC, 8'h00);
      // each secondary source sets its own bit and the pending bit
      for (int i = 1; i < 8; i++) begin
         @(negedge clk);
         faults = 7'(1 << (i - 1));
         @(negedge clk);
         faults = '0;
         cyc(2);
         chk_rd(ADDR_STATUS_PRI, 8'h80);
         chk_rd(ADDR_STATUS_SEC, 8'(1 << i));
         chk_rd(ADDR_STATUS_SEC, 8'h00);
      end
      // window compare at both limits on every analog channel
      for (int c = 0; c < NUM_CH; c++) begin
         measure(c, 8'h80);
         chk_rd(ADDR_STATUS_PRI, 8'h00);
         measure(c, 8'h81);
         measure(c, 8'h40);
         chk_rd(ADDR_STATUS_PRI, 8'(1 << chBit[c]));
         chk_rd(ADDR_STATUS_PRI, 8'h00);
         measure(c, 8'h10);
         chk_rd(ADDR_STATUS_PRI, 8'(1 << chBit[c]));
         measure(c, 8'h40);
         chk_rd(ADDR_STATUS_PRI, 8'(1 << chBit[c]));
         chk_rd(ADDR_STATUS_PRI, 8'h00);
      end
      // alert pin, masks and the masking handler sequence
      pulse_ovt();
      `CHK(alertPinOe, 1'b0)
      rd(ADDR_STATUS_SEC);
      wr(ADDR_ALERT_BOOST_CFG, 8'h01);
      pulse_ovt();
      `CHK(alertPinOe, 1'b1)
      chk_rd(ADDR_STATUS_SEC, 8'h02);
      cyc(3);
      `CHK(alertPinOe, 1'b0)
      wr(ADDR_MASK_SEC, 8'h02);
      pulse_ovt();
      `CHK(alertPinOe, 1'b0)
      chk_rd(ADDR_STATUS_SEC, 8'h02);
      wr(ADDR_MASK_SEC, 8'h00);
      wr(ADDR_MASK_PRI, 8'h80);
      pulse_ovt();
      `CHK(alertPinOe, 1'b0)
      wr(ADDR_MASK_PRI, 8'h01);
      cyc(3);
      `CHK(alertPinOe, 1'b1)
      rd(ADDR_STATUS_SEC);
      measure(CH_CORE, 8'h81);
      cyc(3);
      `CHK(alertPinOe, 1'b0)
      wr(ADDR_MASK_PRI, 8'h00);
      cyc(3);
      `CHK(alertPinOe, 1'b1)
      measure(CH_CORE, 8'h40);
      chk_rd(ADDR_STATUS_PRI, 8'h02);
      cyc(3);
      `CHK(alertPinOe, 1'b0)
      // shared pin as alert output, as general-purpose pin and as fourth speed input
      wr(ADDR_ALERT_BOOST_CFG, 8'h00);
      wr(ADDR_PIN_FUNC_CFG, 8'h02);
      pulse_ovt();
      `CHK(sharedPinOe, 1'b1)
      rd(ADDR_STATUS_SEC);
      cyc(3);
      `CHK(sharedPinOe, 1'b0)
      wr(ADDR_PIN_FUNC_CFG, 8'h03);
      gpioDriveLow = 1'b1;
      cyc(5);
      `CHK(gpioLevel, 1'b0)
      gpioDriveLow = 1'b0;
      cyc(5);
      `CHK(gpioLevel, 1'b1)
      wr(ADDR_PIN_FUNC_CFG, 8'h00);
      hot_start(8'd2);
      `CHK(fourthSpeedInput, 1'b0)
      hot_wait();
      `CHK(fourthSpeedInput, 1'b1)
      // hot input timing, limit and boost
      wr(ADDR_PIN_FUNC_CFG, 8'h01);
      wr(ADDR_ALERT_BOOST_CFG, 8'h07);
      wr(ADDR_HOT_LIMIT, 8'h02);
      rd(ADDR_HOT_ACC);
      rd(ADDR_STATUS_SEC);
      lowCnt = 0;
      hot_start(8'd3);
      `CHK(boostAllFans, 1'b1)
      hot_wait();
      `CHK(boostAllFans, 1'b0)
      `CHK(alertPinOe, 1'b1)
      chk_rd(ADDR_STATUS_SEC, 8'h20);
      hot_start(8'd3);
      hot_wait();
      chk_rd(ADDR_HOT_ACC, 8'((lowCnt < HT) ? 1 : lowCnt / HT));
      chk_rd(ADDR_HOT_ACC, 8'h00);
      chk_rd(ADDR_STATUS_SEC, 8'h00);
      fanRunning = 1'b0;
      hot_start(8'd3);
      `CHK(boostAllFans, 1'b0)
      hot_wait();
      fanRunning = 1'b1;
      wr(ADDR_HOT_LIMIT, 8'h00);
      rd(ADDR_HOT_ACC);
      rd(ADDR_STATUS_SEC);
      hot_start(8'd5);
      cyc(10);
      rd(ADDR_HOT_ACC);
      chk_rd(ADDR_HOT_ACC, 8'h01);
      chk_rd(ADDR_STATUS_SEC, 8'h20);
      hot_wait();
      rd(ADDR_HOT_ACC);
      rd(ADDR_STATUS_SEC);
      wr(ADDR_ALERT_BOOST_CFG, 8'h04);
      hot_start(8'd2);
      `CHK(boostAllFans, 1'b0)
      hot_wait();
      chk_rd(ADDR_HOT_ACC, 8'h00);
      wr(ADDR_ALERT_BOOST_CFG, 8'h02);
      hot_start(8'd210);
      hot_wait();
      chk_rd(ADDR_HOT_ACC, ACC_FULL);
      final_report();
   end
endmodule
`default_nettype wire
